// ---- design/cmp_pkg.sv ----
// Constants and carrier types for the analog comparator control block.
// Assumes one 200 MHz clock and a plain strobe register port with 8-bit data.
package cmp_pkg;

  // Register offsets
  localparam logic [7:0] ctrl_addr = 8'h9C;
  localparam logic [7:0] cfg_addr = 8'h9D;
  localparam logic [7:0] irq_status_addr = 8'hA0;
  localparam logic [7:0] irq_mask_addr = 8'hA1;

  // Control register field positions
  localparam int on_bit = 7;
  localparam int result_bit = 6;
  localparam int pos_lsb = 3;
  localparam int neg_lsb = 0;

  // Config register field positions
  localparam int debounce_lsb = 2;
  localparam int edge_lsb = 0;

  // Interrupt status and mask bit positions
  localparam int irq_event_bit = 0;
  localparam int irq_wake_bit = 1;

  // Reset values
  localparam logic [7:0] ctrl_reset = 8'h40;
  localparam logic [3:0] cfg_reset = 4'h0;
  localparam logic [1:0] irq_mask_reset = 2'h0;

  // Positive source codes
  localparam logic [1:0] pos_quarter = 2'h0;
  localparam logic [1:0] pos_half = 2'h1;
  localparam logic [1:0] pos_three_quarter = 2'h2;
  localparam logic [1:0] pos_external = 2'h3;

  // De-bounce codes and filter lengths in CPU clocks
  localparam logic [1:0] debounce_bypass = 2'h3;
  localparam logic [1:0] filter_len_00 = 2'h1;

  // Edge select codes
  localparam logic [1:0] edge_rising = 2'h1;
  localparam logic [1:0] edge_falling = 2'h2;
  localparam logic [1:0] edge_both = 2'h3;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Analog front-end steering
  typedef struct packed {
    logic [7:0] pin_input_force;
    logic [7:0] pin_analog_route;
    logic [2:0] neg_channel;
    logic pos_from_pin;
    logic ref_gen_on;
    logic [1:0] ref_level;
    logic comparator_power;
  } analog_ctrl_s;

endpackage

// ---- design/analog_comparator_control.sv ----
// Control, filter, event and interrupt logic around one analog comparator.
// Holds the two comparator registers plus a status and a mask register.
// Steering for the analog front end and pin directions leaves on flops.
// Green mode comes from the same clock domain and needs no synchroniser.
// Assumes the raw comparator output arrives asynchronously and the register
// master follows the one-cycle strobe protocol of the system bus.
`timescale 1ns/1ps
`default_nettype none

module analog_comparator_control (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Analog side
  input wire logic comparator_raw,
  input wire logic [7:0] gpio_dir_out,
  output logic [7:0] pin_dir_out,
  output cmp_pkg::analog_ctrl_s analog_ctrl,
  // Power mode and system events
  input wire logic green_mode,
  output logic wake_request,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  // Registers end in _reg; combinational helpers carry no suffix

  cmp_pkg::reg_req_s req; // Bundled bus request
  logic ctrl_write; // Control register written this cycle
  logic cfg_write; // Config register written this cycle
  logic mask_write; // Mask register written this cycle
  logic status_write; // Status register written this cycle
  logic [1:0] status_clear; // Status bits software clears
  // Register fields
  logic comparator_on_reg; // Comparator enable
  logic [1:0] positive_source_select_reg; // Positive source code
  logic [2:0] negative_channel_select_reg; // Negative pin code
  logic [1:0] debounce_select_reg; // Filter length code
  logic [1:0] event_edge_select_reg; // Edge code
  // Interrupt state
  logic [1:0] irq_status_reg; // Sticky event and wake bits
  logic [1:0] irq_mask_reg; // Interrupt enables
  // Comparator path and filter
  logic [2:0] sync_reg; // Three-stage input synchroniser
  logic sync_level; // Agreed synchronised level
  logic [1:0] run_count_reg; // Cycles the new level has held
  logic filtered_reg; // De-bounced comparator output
  logic filtered_prev_reg; // Last filtered value for edges
  logic [1:0] filter_len; // Clocks a level must hold
  logic filtered_next; // Next filter output
  // Result and events
  logic result_flag; // Value shown in the result bit
  logic rise; // Filtered rising edge
  logic fall; // Filtered falling edge
  logic event_hit; // Selected edge seen
  // Steering outputs
  logic [7:0] neg_onehot; // Pin chosen as negative input
  logic [7:0] force_in; // Pins forced to input
  cmp_pkg::analog_ctrl_s analog_next; // Next steering word

  // Bundle the strobe port so every decoder reads one carrier
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Address decode: one write strobe per register, exact match only
  assign ctrl_write = req.wr && req.addr == cmp_pkg::ctrl_addr;
  assign cfg_write = req.wr && req.addr == cmp_pkg::cfg_addr;
  assign mask_write = req.wr && req.addr == cmp_pkg::irq_mask_addr;
  assign status_write = req.wr && req.addr == cmp_pkg::irq_status_addr;
  // Write one to clear; zeros leave a status bit alone
  assign status_clear = status_write ? req.wdata[1:0] : 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Control register writes
  // Every write lands on the edge that samples its strobe; the bus never waits

  // Enable and input selection fields
  // Bits 6 and 5 of the write data are dropped: result is read-only
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      comparator_on_reg <= cmp_pkg::ctrl_reset[cmp_pkg::on_bit];
      positive_source_select_reg <= cmp_pkg::ctrl_reset[cmp_pkg::pos_lsb +: 2];
      negative_channel_select_reg <= cmp_pkg::ctrl_reset[cmp_pkg::neg_lsb +: 3];
    end else if (ctrl_write) begin
      // Result bit is ignored on write
      comparator_on_reg <= req.wdata[cmp_pkg::on_bit];
      positive_source_select_reg <= req.wdata[cmp_pkg::pos_lsb +: 2];
      negative_channel_select_reg <= req.wdata[cmp_pkg::neg_lsb +: 3];
    end
  end

  // Filter and edge configuration
  // Reserved edge code 00 is kept as written and simply raises no event
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      debounce_select_reg <= cmp_pkg::cfg_reset[cmp_pkg::debounce_lsb +: 2];
      event_edge_select_reg <= cmp_pkg::cfg_reset[cmp_pkg::edge_lsb +: 2];
    end else if (cfg_write) begin
      debounce_select_reg <= req.wdata[cmp_pkg::debounce_lsb +: 2];
      event_edge_select_reg <= req.wdata[cmp_pkg::edge_lsb +: 2];
    end
  end

  // Interrupt mask, same layout as the status register
  // A set mask bit lets its status bit drive irq
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_mask_reg <= cmp_pkg::irq_mask_reset;
    end else if (mask_write) begin
      irq_mask_reg <= req.wdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input synchroniser and de-bounce filter
  // The raw comparator output is asynchronous to the clock

  // Three flops; a change counts once the last two agree
  // Only the second stage reads the first, so a metastable first stage
  // never reaches the filter directly
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync_reg <= 3'h7;
    end else begin
      sync_reg <= {sync_reg[1:0], comparator_raw};
    end
  end

  // While the stages disagree the filter sees its own output: no change
  assign sync_level = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : filtered_reg;

  // Filter length from the de-bounce code: 00 one, 01 two, 10 three
  always_comb begin
    // Code 11 wraps to zero here, but the bypass branch never reads it
    filter_len = debounce_select_reg + cmp_pkg::filter_len_00;
  end

  // Next output: bypass follows at once, else after the level holds
  // A new level must hold for filter_len clocks before it passes, so
  // code 00 adds one clock over the bypass path
  always_comb begin
    if (debounce_select_reg == cmp_pkg::debounce_bypass) begin
      filtered_next = sync_level;
    end else if (sync_level != filtered_reg && run_count_reg >= filter_len) begin
      filtered_next = sync_level;
    end else begin
      filtered_next = filtered_reg;
    end
  end

  // Hold counter for a differing level
  // Zero on the first differing cycle; it saturates so a long run
  // cannot wrap back below the threshold
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      run_count_reg <= 2'h0;
    end else if (sync_level == filtered_next) begin
      run_count_reg <= 2'h0;
    end else if (run_count_reg != 2'h3) begin
      run_count_reg <= run_count_reg + 2'h1;
    end
  end

  // Filtered output; forced high while off so enabling starts from one
  // Forcing both stages high keeps a disabled comparator free of edges
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      filtered_reg <= 1'b1;
      filtered_prev_reg <= 1'b1;
    end else if (!comparator_on_reg) begin
      // Disabled: hold the idle level
      filtered_reg <= 1'b1;
      filtered_prev_reg <= 1'b1;
    end else begin
      filtered_reg <= filtered_next;
      filtered_prev_reg <= filtered_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result, edges and events
  // Events come from the filtered output only, never from the raw one

  // Result reads one while disabled, else the filtered compare
  // The flag follows the filter, so it never shows a rejected glitch
  assign result_flag = comparator_on_reg ? filtered_reg : 1'b1;

  // Edges on the filtered output only
  assign rise = filtered_reg && !filtered_prev_reg;
  assign fall = !filtered_reg && filtered_prev_reg;

  // Selected edge; reserved code raises nothing
  // Both edges fire on any change of the filtered output
  always_comb begin
    unique case (event_edge_select_reg)
      cmp_pkg::edge_rising: event_hit = rise;
      cmp_pkg::edge_falling: event_hit = fall;
      cmp_pkg::edge_both: event_hit = rise || fall;
      default: event_hit = 1'b0;
    endcase
  end

  // Sticky status, write one to clear; a new event wins over the clear
  // so an edge in the clearing cycle is never lost
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_status_reg <= 2'h0;
    end else begin
      // Event bit follows the selected edge
      if (event_hit) begin
        irq_status_reg[cmp_pkg::irq_event_bit] <= 1'b1;
      end else if (status_clear[cmp_pkg::irq_event_bit]) begin
        irq_status_reg[cmp_pkg::irq_event_bit] <= 1'b0;
      end
      // Wake bit records any filtered change in green mode
      if (green_mode && (rise || fall)) begin
        irq_status_reg[cmp_pkg::irq_wake_bit] <= 1'b1;
      end else if (status_clear[cmp_pkg::irq_wake_bit]) begin
        irq_status_reg[cmp_pkg::irq_wake_bit] <= 1'b0;
      end
    end
  end

  // Interrupt level from unmasked status
  // Registered, so it trails the status bits by one clock
  // Mask bits gate the status bits one for one
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Green-mode wake on any filtered change
  // One pulse per change; power-down has no wake path in this block
  // Wake needs no mask; it is a system event, not an interrupt
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= green_mode && (rise || fall);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin steering
  // Only an enabled comparator takes pins away from GPIO control

  // One-hot of the negative channel
  assign neg_onehot = 8'h01 << negative_channel_select_reg;

  // Pins forced to input: negative pin, plus pin zero for external positive
  // A pin used as an analog input must never be driven by its GPIO side
  always_comb begin
    force_in = 8'h00;
    if (comparator_on_reg) begin
      force_in = neg_onehot;
      if (positive_source_select_reg == cmp_pkg::pos_external) begin
        force_in[0] = 1'b1;
      end
    end
  end

  // Analog steering word
  // Reference level is passed even when the pin source is chosen
  always_comb begin
    analog_next.pin_input_force = force_in;
    analog_next.pin_analog_route = force_in;
    analog_next.neg_channel = negative_channel_select_reg;
    analog_next.pos_from_pin = comparator_on_reg &&
                               positive_source_select_reg == cmp_pkg::pos_external;
    analog_next.ref_gen_on = comparator_on_reg &&
                             positive_source_select_reg != cmp_pkg::pos_external;
    analog_next.ref_level = positive_source_select_reg;
    analog_next.comparator_power = comparator_on_reg;
  end

  // Registered steering and directions; released pins take GPIO direction back
  // Directions follow gpio_dir_out again on the edge after a pin is released
  // Reset leaves every pin as input until the first clock after reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      analog_ctrl <= '0;
      pin_dir_out <= 8'h00;
    end else begin
      analog_ctrl <= analog_next;
      pin_dir_out <= gpio_dir_out & ~force_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port
  // Fixed layout; unused bits read zero

  // Read data one cycle after the strobe; unmapped reads zero
  // Reads have no side effects; status bits clear only by writing ones
  // Data drop back to zero after one cycle so stale values never linger
  // Control reads show the live enable and result bits
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        cmp_pkg::ctrl_addr: reg_rdata <= {comparator_on_reg, result_flag, 1'b0,
                                          positive_source_select_reg, negative_channel_select_reg};
        cmp_pkg::cfg_addr: reg_rdata <= {4'h0, debounce_select_reg, event_edge_select_reg};
        cmp_pkg::irq_status_addr: reg_rdata <= {6'h00, irq_status_reg};
        cmp_pkg::irq_mask_addr: reg_rdata <= {6'h00, irq_mask_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ---- test/cmp_analog_model.sv ----
// Behavioural model of the port-one analog pins and the comparator core.
// Assumes pin voltages as 8-bit codes on a 256 full scale, supply = 256.
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model (
  // Steering from the block
  input wire cmp_pkg::analog_ctrl_s ctrl,
  // Pin voltages, pin n in bits 8n+7..8n
  input wire logic [63:0] volts,
  // Comparator decision
  output logic raw
);
  logic [8:0] pos; // Positive input level
  logic [7:0] neg; // Negative input level
  // Reference taps at 1/4, 1/2, 3/4 of supply, or pin zero
  always_comb begin
    pos = ctrl.pos_from_pin ? {1'b0, volts[7:0]} : 9'((ctrl.ref_level + 1) * 64);
    neg = volts[ctrl.neg_channel * 8 +: 8];
    raw = pos > {1'b0, neg};
  end
endmodule
`default_nettype wire

// ---- test/analog_comparator_control_assertions.sv ----
// Port-level checker for the comparator control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  // Analog side and events
  input wire logic [7:0] gpio_dir_out,
  input wire logic [7:0] pin_dir_out,
  input wire cmp_pkg::analog_ctrl_s analog_ctrl,
  input wire logic green_mode,
  input wire logic wake_request,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic on; // Comparator powered
  assign on = analog_ctrl.comparator_power;
  a_off_no_route: assert property (!on |-> analog_ctrl.pin_analog_route == 8'h00)
    else $error("pin routed while comparator off");
  a_off_gpio_dir: assert property (!on ##1 !on |-> pin_dir_out == $past(gpio_dir_out))
    else $error("pin direction differs from GPIO while off");
  a_route_neg_pin: assert property (on |-> analog_ctrl.pin_analog_route[analog_ctrl.neg_channel]
    && !pin_dir_out[analog_ctrl.neg_channel]) else $error("negative pin not routed as input");
  a_ext_pos_pin: assert property (on && analog_ctrl.pos_from_pin |-> analog_ctrl.pin_input_force[0]
    && !pin_dir_out[0] && !analog_ctrl.ref_gen_on) else $error("external positive pin misconfigured");
  a_ref_gen_on: assert property (on && !analog_ctrl.pos_from_pin |-> analog_ctrl.ref_gen_on)
    else $error("reference generator off with internal source");
  a_irq_held: assert property ($fell(irq) |-> $past(reg_wr, 2))
    else $error("interrupt dropped without a write");
  a_result_off_one: assert property ($past(reg_rd && reg_addr == cmp_pkg::ctrl_addr) && !on
    && !$past(on) |-> reg_rdata[cmp_pkg::result_bit]) else $error("result flag low while off");
  a_wake_green: assert property (wake_request |-> $past(green_mode))
    else $error("wake request outside green mode");
endmodule
bind analog_comparator_control analog_comparator_control_assertions u_analog_comparator_control_assertions (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .gpio_dir_out(gpio_dir_out), .pin_dir_out(pin_dir_out), .analog_ctrl(analog_ctrl), .green_mode(green_mode),
  .wake_request(wake_request), .irq(irq));
`default_nettype wire

// ---- test/analog_comparator_control_test.sv ----
// Register-level testbench for the comparator control block.
// Assumes the analog model drives the raw comparator output.
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_test;
  logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, green_mode = 0, wake_request, irq, comparator_raw;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, gpio_dir_out = 8'hFF, pin_dir_out;
  logic [63:0] volts = {8{8'h40}}; // All pins below the half reference
  cmp_pkg::analog_ctrl_s analog_ctrl;
  int miscompares = 0, check_count = 0, wakes = 0;
  initial forever #2.5 clock = ~clock;
  analog_comparator_control u_analog_comparator_control (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comparator_raw(comparator_raw), .gpio_dir_out(gpio_dir_out), .pin_dir_out(pin_dir_out),
    .analog_ctrl(analog_ctrl), .green_mode(green_mode), .wake_request(wake_request), .irq(irq));
  cmp_analog_model u_cmp_analog_model (.ctrl(analog_ctrl), .volts(volts), .raw(comparator_raw));
  // Count wake pulses
  always @(posedge clock) if (wake_request === 1'b1) wakes <= wakes + 1;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge clock);
  endtask
  // Pin three sets the result high (1) or low (0) against the half reference, then wait
  task automatic lvl(input logic hi, input int n);
    volts[31:24] <= hi ? 8'h40 : 8'hC0;
    repeat (n) @(posedge clock);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(cmp_pkg::ctrl_addr, cmp_pkg::ctrl_reset);
    rd(cmp_pkg::cfg_addr, 8'h00);
    rd(cmp_pkg::irq_mask_addr, 8'h00);
    rd(8'hA5, 8'h00);
    check(pin_dir_out, 8'hFF);
    $display("Reset test done");
    // Every source code against every safe channel
    for (int p = 0; p < 4; p++)
      for (int n = 1; n < 8; n++) begin
        wr(cmp_pkg::ctrl_addr, 8'(8'h80 | p << 3 | n));
        repeat (3) @(posedge clock);
        check(analog_ctrl.pin_analog_route | 8'h01, 8'(1 << n | 1));
        check(pin_dir_out, 8'(~(1 << n)) & (p == 3 ? 8'hFE : 8'hFF));
        check(8'(analog_ctrl.ref_gen_on), 8'(p != 3));
        if (p < 3) check(8'(analog_ctrl.ref_level), 8'(p));
      end
    wr(cmp_pkg::ctrl_addr, 8'h0B);
    repeat (3) @(posedge clock);
    check(pin_dir_out, 8'hFF);
    $display("Steering test done");
    wr(cmp_pkg::ctrl_addr, 8'h8B);
    lvl(1, 10);
    rd(cmp_pkg::ctrl_addr, 8'hCB);
    lvl(0, 10);
    rd(cmp_pkg::ctrl_addr, 8'h8B);
    wr(cmp_pkg::ctrl_addr, 8'h0B);
    rd(cmp_pkg::ctrl_addr, 8'h4B);
    wr(cmp_pkg::ctrl_addr, 8'h8B);
    $display("Result test done");
    wr(cmp_pkg::irq_mask_addr, 8'h01);
    for (int e = 1; e < 4; e++) begin
      wr(cmp_pkg::cfg_addr, 8'(12 + e));
      lvl(1, 10);
      wr(cmp_pkg::irq_status_addr, 8'h03);
      lvl(0, 10);
      rd(cmp_pkg::irq_status_addr, 8'(e >> 1));
      check(8'(irq), 8'(e >> 1));
      wr(cmp_pkg::irq_status_addr, 8'h03);
      lvl(1, 10);
      rd(cmp_pkg::irq_status_addr, 8'(e & 1));
      wr(cmp_pkg::irq_status_addr, 8'h03);
    end
    wr(cmp_pkg::irq_mask_addr, 8'h00);
    lvl(0, 10);
    check(8'(irq), 8'h00);
    $display("Edge test done");
    // Short glitch is filtered, long pulses pass every setting
    wr(cmp_pkg::cfg_addr, 8'h0B);
    lvl(1, 10);
    wr(cmp_pkg::irq_status_addr, 8'h03);
    lvl(0, 2);
    lvl(1, 10);
    rd(cmp_pkg::irq_status_addr, 8'h00);
    for (int d = 0; d < 4; d++) begin
      wr(cmp_pkg::cfg_addr, 8'(d << 2 | 3));
      lvl(0, 6);
      lvl(1, 10);
      rd(cmp_pkg::irq_status_addr, 8'h01);
      wr(cmp_pkg::irq_status_addr, 8'h03);
    end
    // Two-clock dip: the one-clock filter holds it back, bypass passes it
    wr(cmp_pkg::cfg_addr, 8'h03);
    lvl(0, 2);
    lvl(1, 10);
    rd(cmp_pkg::irq_status_addr, 8'h00);
    wr(cmp_pkg::cfg_addr, 8'h0F);
    lvl(0, 2);
    lvl(1, 10);
    rd(cmp_pkg::irq_status_addr, 8'h01);
    wr(cmp_pkg::irq_status_addr, 8'h03);
    $display("Filter test done");
    green_mode <= 1'b1;
    lvl(0, 10);
    green_mode <= 1'b0;
    check(8'(wakes > 0), 8'h01);
    rd(cmp_pkg::irq_status_addr, 8'h03);
    $display("Wake test done");
    // Reset in mid-run with the comparator enabled and status set
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(cmp_pkg::ctrl_addr, cmp_pkg::ctrl_reset);
    rd(cmp_pkg::irq_status_addr, 8'h00);
    check(pin_dir_out, 8'hFF);
    $display("Second reset test done");
    test_done();
  end
endmodule
`default_nettype wire
